// file: hdl/tsr_regs.svh
// Command codes, field positions, reset values and timing counts
`ifndef TSR_REGS_SVH
`define TSR_REGS_SVH

// Command byte codes
`define TSR_CMD_DEGREES     8'h00
`define TSR_CMD_SETTINGS    8'h01

// Settings register fields
`define TSR_STANDBY_BIT     7
`define TSR_READY_BIT       6
`define TSR_RESERVED_ZERO   6'h00

// Reset values
`define TSR_SETTINGS_RESET  8'h00
`define TSR_DEGREES_RESET   8'h00
`define TSR_UNMAPPED_READ   8'h00

// Serial framing
`define TSR_BYTE_BITS       4'h8
`define TSR_DEV_ADDR        7'h48

// Rounding and clamping, whole degrees in 11-bit two's complement
`define TSR_HALF_DEGREE     13'sh0002
`define TSR_DEG_MAX         11'sh07F
`define TSR_DEG_MIN         11'sh780
`define TSR_CODE_MAX        8'h7F
`define TSR_CODE_MIN        8'h80

// Conversion timing at 125 MHz
`define TSR_CLK_PERIOD_NS   8
`define TSR_CONV_PERIOD_NS  125000000
`define TSR_CONV_CYCLES     (`TSR_CONV_PERIOD_NS / `TSR_CLK_PERIOD_NS)

`endif

// file: hdl/tsr_pkg.sv
// Types shared by the temperature sensor register set
package tsr_pkg;

   // Serial slave states, one-hot
   typedef enum logic [8:0] {
      TSR_IDLE  = 9'h001,
      TSR_ADDR  = 9'h002,
      TSR_AACK  = 9'h004,
      TSR_CMD   = 9'h008,
      TSR_CACK  = 9'h010,
      TSR_WDATA = 9'h020,
      TSR_WACK  = 9'h040,
      TSR_RDATA = 9'h080,
      TSR_RACK  = 9'h100
   } tsr_state_t;

   // Stored bits of the settings register
   typedef struct packed {
      logic standby_request;
      logic ready;
   } tsr_settings_t;

endpackage

// file: hdl/tsr_top.sv
// Temperature sensor register set with its serial slave and converter
`timescale 1ns/1ns
`default_nettype none
`include "tsr_regs.svh"

module tsr_top #(
   parameter logic [6:0]  DEV_ADDR    = `TSR_DEV_ADDR,
   parameter int unsigned CONV_CYCLES = `TSR_CONV_CYCLES
) (
   // Clock and reset
   input  wire logic               i_clock,
   input  wire logic               i_rst,
   // Serial bus pins, data is open drain
   input  wire logic               i_scl,
   input  wire logic               i_sda,
   output logic                    o_sda_out,
   output logic                    o_sda_oe,
   // Converter sample, quarter degrees, two's complement
   input  wire logic signed [11:0] i_sensed_quarters,
   // Observed state
   output logic             [7:0]  o_degrees,
   output logic                    o_standby,
   output logic                    o_ready
);

   // Read mux shared by address ack and master ack paths
   function automatic logic [7:0] tsr_read(
      input logic [7:0]             cmd,
      input logic [7:0]             deg,
      input tsr_pkg::tsr_settings_t set
   );
      case (cmd)
         `TSR_CMD_DEGREES:  tsr_read = deg;
         `TSR_CMD_SETTINGS: tsr_read = {set.standby_request,
                                        set.ready,
                                        `TSR_RESERVED_ZERO};
         default:           tsr_read = `TSR_UNMAPPED_READ;
      endcase
   endfunction

   // Pin history for edge and condition detection
   logic scl_q;
   logic sda_q;
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;

   // Serial slave state
   tsr_pkg::tsr_state_t state;
   tsr_pkg::tsr_state_t next_state;
   logic [3:0]          cnt;
   logic [3:0]          next_cnt;
   logic [7:0]          sh;
   logic [7:0]          next_sh;
   logic [7:0]          ptr;
   logic [7:0]          next_ptr;
   logic                rw;
   logic                next_rw;
   logic                sda_oe;
   logic                next_sda_oe;
   logic                wr_settings;
   logic [7:0]          rd_byte;

   // Sensor state
   tsr_pkg::tsr_settings_t set;
   tsr_pkg::tsr_settings_t next_set;
   logic [7:0]             deg;
   logic [7:0]             next_deg;
   logic [23:0]            timer;
   logic [23:0]            next_timer;
   logic                   conv_done;
   logic signed [12:0]     rounded;
   logic signed [10:0]     whole;
   logic [7:0]             code;

   // Bus events
   assign scl_rise   = ~scl_q & i_scl;
   assign scl_fall   = scl_q & ~i_scl;
   assign start_seen = scl_q & i_scl & sda_q & ~i_sda;
   assign stop_seen  = scl_q & i_scl & ~sda_q & i_sda;
   assign rd_byte    = tsr_read(ptr, deg, set);

   // Slave sequencing; stop and start override any state
   always_comb
   begin
      next_state  = state;
      next_cnt    = cnt;
      next_sh     = sh;
      next_ptr    = ptr;
      next_rw     = rw;
      next_sda_oe = sda_oe;
      wr_settings = 1'b0;
      if (stop_seen)
      begin
         next_state  = tsr_pkg::TSR_IDLE;
         next_sda_oe = 1'b0;
      end
      else if (start_seen)
      begin
         next_state  = tsr_pkg::TSR_ADDR;
         next_cnt    = 4'h0;
         next_sda_oe = 1'b0;
      end
      else
      begin
         case (state)
            tsr_pkg::TSR_ADDR, tsr_pkg::TSR_CMD, tsr_pkg::TSR_WDATA:
            begin
               if (scl_rise)
               begin
                  next_sh  = {sh[6:0], i_sda};
                  next_cnt = cnt + 4'h1;
               end
               else if (scl_fall && cnt == `TSR_BYTE_BITS)
               begin
                  next_cnt    = 4'h0;
                  next_sda_oe = 1'b1;
                  if (state == tsr_pkg::TSR_ADDR)
                  begin
                     // Foreign address: stay off the bus until next start
                     if (sh[7:1] == DEV_ADDR)
                     begin
                        next_rw    = sh[0];
                        next_state = tsr_pkg::TSR_AACK;
                     end
                     else
                     begin
                        next_sda_oe = 1'b0;
                        next_state  = tsr_pkg::TSR_IDLE;
                     end
                  end
                  else if (state == tsr_pkg::TSR_CMD)
                  begin
                     next_ptr   = sh;
                     next_state = tsr_pkg::TSR_CACK;
                  end
                  else
                  begin
                     wr_settings = (ptr == `TSR_CMD_SETTINGS);
                     next_state  = tsr_pkg::TSR_WACK;
                  end
               end
            end
            tsr_pkg::TSR_AACK, tsr_pkg::TSR_RACK:
            begin
               // Master nack ends a read; ack asks for the byte again
               if (state == tsr_pkg::TSR_RACK && scl_rise && i_sda)
                  next_state = tsr_pkg::TSR_IDLE;
               else if (scl_fall && rw)
               begin
                  next_sh     = rd_byte;
                  next_sda_oe = ~rd_byte[7];
                  next_state  = tsr_pkg::TSR_RDATA;
               end
               else if (scl_fall)
               begin
                  next_sda_oe = 1'b0;
                  next_state  = tsr_pkg::TSR_CMD;
               end
            end
            tsr_pkg::TSR_CACK, tsr_pkg::TSR_WACK:
            begin
               // Extra data bytes land in the same register
               if (scl_fall)
               begin
                  next_sda_oe = 1'b0;
                  next_state  = tsr_pkg::TSR_WDATA;
               end
            end
            tsr_pkg::TSR_RDATA:
            begin
               if (scl_rise)
                  next_cnt = cnt + 4'h1;
               else if (scl_fall && cnt == `TSR_BYTE_BITS)
               begin
                  next_cnt    = 4'h0;
                  next_sda_oe = 1'b0;
                  next_state  = tsr_pkg::TSR_RACK;
               end
               else if (scl_fall)
               begin
                  next_sh     = {sh[6:0], 1'b0};
                  next_sda_oe = ~sh[6];
               end
            end
            default:
               next_state = tsr_pkg::TSR_IDLE;
         endcase
      end
   end

   // Slave registers; pins are synchronous, one history stage will do
   always_ff @(posedge i_clock)
   begin
      if (i_rst)
      begin
         state  <= tsr_pkg::TSR_IDLE;
         cnt    <= 4'h0;
         sh     <= 8'h00;
         ptr    <= `TSR_CMD_DEGREES;
         rw     <= 1'b0;
         sda_oe <= 1'b0;
         scl_q  <= 1'b1;
         sda_q  <= 1'b1;
      end
      else
      begin
         state  <= next_state;
         cnt    <= next_cnt;
         sh     <= next_sh;
         ptr    <= next_ptr;
         rw     <= next_rw;
         sda_oe <= next_sda_oe;
         scl_q  <= i_scl;
         sda_q  <= i_sda;
      end
   end

   // Round half toward positive, then clamp to the 8-bit range
   assign rounded = 13'(i_sensed_quarters) + `TSR_HALF_DEGREE;
   assign whole   = rounded[12:2];
   assign code    = (whole > `TSR_DEG_MAX) ? `TSR_CODE_MAX :
                    (whole < `TSR_DEG_MIN) ? `TSR_CODE_MIN :
                    whole[7:0];
   assign conv_done = ~set.standby_request &&
                      timer == 24'(CONV_CYCLES - 1);

   // Converter timing, result load and settings writes
   always_comb
   begin
      next_set   = set;
      next_deg   = deg;
      next_timer = timer + 24'h000001;
      // Held at zero in standby, so a restart waits a full period
      if (set.standby_request || conv_done)
         next_timer = 24'h000000;
      if (conv_done)
      begin
         next_deg       = code;
         next_set.ready = 1'b1;
      end
      // Standby written 1 wins over a result landing in the same cycle
      if (wr_settings)
      begin
         next_set.standby_request = sh[`TSR_STANDBY_BIT];
         if (sh[`TSR_STANDBY_BIT])
         begin
            next_deg       = deg;              // Never load unflagged
            next_set.ready = 1'b0;
            next_timer     = 24'h000000;
         end
      end
   end

   // Sensor registers, all zero at power-on
   always_ff @(posedge i_clock)
   begin
      if (i_rst)
      begin
         set       <= tsr_pkg::tsr_settings_t'(2'b00);
         deg       <= `TSR_DEGREES_RESET;
         timer     <= 24'h000000;
         o_sda_out <= 1'b0;
      end
      else
      begin
         set       <= next_set;
         deg       <= next_deg;
         timer     <= next_timer;
         o_sda_out <= 1'b0;
      end
   end

   // Outputs are the flops themselves
   assign o_sda_oe  = sda_oe;
   assign o_degrees = deg;
   assign o_standby = set.standby_request;
   assign o_ready   = set.ready;

endmodule
`default_nettype wire

// file: sim/tsr_top_assertions.sv
// Port checker for the sensor register set, bound to the top module
`timescale 1ns/1ns
`default_nettype none
module tsr_top_checker #(
   parameter int unsigned CONV_CYCLES = 50
) (
   // Clock and reset
   input wire logic              i_clock,
   input wire logic              i_rst,
   // Bus and converter
   input wire logic              i_scl,
   input wire logic              o_sda_oe,
   input wire logic signed [11:0] i_sensed_quarters,
   // Register state
   input wire logic [7:0]        o_degrees,
   input wire logic              o_standby,
   input wire logic              o_ready
);
   localparam int FIRST_MAX = 1000;
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);
   // Half up rounding, clamped to the 8-bit code range
   function automatic logic [7:0] rnd(input logic signed [11:0] v);
      logic signed [12:0] s;
      s = v;
      s = (s + 13'sh0002) >>> 2;
      return s > 13'sh007F ? 8'h7F : s < 13'sh1F80 ? 8'h80 : s[7:0];
   endfunction
   property p_rst_vals;
      $fell(i_rst) |-> o_degrees == 8'h00 && !o_ready && !o_standby
         && !o_sda_oe;
   endproperty
   a_rst_vals: assert property (p_rst_vals)
      else $error("registers not cleared by reset");
   property p_oe_low;
      $changed(o_sda_oe) |-> !i_scl && !$past(i_scl);
   endproperty
   a_oe_low: assert property (p_oe_low)
      else $error("data drive changed with bus clock high");
   property p_sb_no_rdy;
      o_standby |-> !o_ready;
   endproperty
   a_sb_no_rdy: assert property (p_sb_no_rdy)
      else $error("ready flag set during standby");
   property p_rdy_keep;
      o_ready |=> o_ready || o_standby;
   endproperty
   a_rdy_keep: assert property (p_rdy_keep)
      else $error("ready flag dropped without standby");
   property p_deg_hold;
      o_standby |=> $stable(o_degrees);
   endproperty
   a_deg_hold: assert property (p_deg_hold)
      else $error("reading moved during standby");
   property p_deg_val;
      $changed(o_degrees) |-> o_degrees == rnd($past(i_sensed_quarters));
   endproperty
   a_deg_val: assert property (p_deg_val)
      else $error("reading not rounded or clamped");
   property p_load_rdy;
      $changed(o_degrees) |-> o_ready;
   endproperty
   a_load_rdy: assert property (p_load_rdy)
      else $error("reading loaded without ready");
   property p_first_rdy;
      $fell(i_rst) |-> ##[1:FIRST_MAX] o_ready;
   endproperty
   a_first_rdy: assert property (p_first_rdy)
      else $error("no conversion after reset");
   // Main scenarios reached
   c_standby: cover property ($rose(o_standby));
   c_ack: cover property ($rose(o_sda_oe));
   c_clamp: cover property ($changed(o_degrees) && o_degrees == 8'h80);
endmodule
bind tsr_top tsr_top_checker #(.CONV_CYCLES(CONV_CYCLES)) tsr_top_checker_inst (
   .i_clock(i_clock), .i_rst(i_rst), .i_scl(i_scl), .o_sda_oe(o_sda_oe),
   .i_sensed_quarters(i_sensed_quarters), .o_degrees(o_degrees),
   .o_standby(o_standby), .o_ready(o_ready));
`default_nettype wire

// file: sim/tsr_host_model.sv
// Bus master model on the sensor's clock and open-drain data pins
`timescale 1ns/1ns
`default_nettype none
module tsr_host_model (
   // Clock and device pull-down
   input  wire logic       i_clock,
   input  wire logic       i_sda_oe,
   // Bus pins
   output logic            o_scl,
   output wire logic       o_sda,
   // One report per byte: ack bit or read data
   output logic            o_got,
   output logic [7:0]      o_rx
);
   logic drv = 1'b1;
   int   half = 4;
   // Pull-up wins unless either side pulls low
   assign o_sda = drv & ~i_sda_oe;
   initial
   begin
      o_scl = 1'b1;
      o_got = 1'b0;
      o_rx = 8'h00;
   end
   // Phase length; at least 3 so the device sees every edge
   task automatic tick();
      repeat (half) @(negedge i_clock);
   endtask
   task automatic bit_io(input logic b, output logic r);
      drv = b;
      tick();
      o_scl = 1'b1;
      tick();
      r = o_sda;
      o_scl = 1'b0;
   endtask
   // Start or repeated start
   task automatic start();
      drv = 1'b1;
      tick();
      o_scl = 1'b1;
      tick();
      drv = 1'b0;
      tick();
      o_scl = 1'b0;
   endtask
   task automatic stop();
      drv = 1'b0;
      tick();
      o_scl = 1'b1;
      tick();
      drv = 1'b1;
      tick();
   endtask
   // Eight bits MSB first, then the ninth pulse
   task automatic xfer(input logic [7:0] w, input logic m, input logic rd);
      logic [7:0] r;
      logic       a;
      for (int i = 7; i >= 0; i--)
         bit_io(w[i], r[i]);
      bit_io(m, a);
      o_rx = rd ? r : {7'h00, a};
      o_got = 1'b1;
      @(negedge i_clock);
      o_got = 1'b0;
   endtask
endmodule
`default_nettype wire

// file: sim/tb.sv
// Self-checking bench for the sensor register set
`timescale 1ns/1ns
`default_nettype none
module tb;
   localparam int CONV = 900;
   logic               clk = 1'b0;
   logic               rst = 1'b1;
   logic               scl, sda, oe, sda_out, got, standby, ready;
   logic [7:0]         rx, deg, v;
   logic signed [11:0] q = 12'sh000;
   logic signed [11:0] tv [8];
   logic [7:0]         exp_q [$];
   int                 err_count = 0;
   int                 samples_checked = 0;
   always #4 clk = ~clk;
   tsr_top #(.CONV_CYCLES(CONV)) tsr_top_inst (.i_clock(clk), .i_rst(rst),
      .i_scl(scl), .i_sda(sda), .o_sda_out(sda_out), .o_sda_oe(oe),
      .i_sensed_quarters(q), .o_degrees(deg), .o_standby(standby),
      .o_ready(ready));
   tsr_host_model tsr_host_model_inst (.i_clock(clk), .i_sda_oe(oe),
      .o_scl(scl), .o_sda(sda), .o_got(got), .o_rx(rx));
   task automatic chk(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
      samples_checked++;
      if (g !== e)
      begin
         err_count++;
         $display("unexpected %s exp %h got %h", nm, e, g);
      end
   endtask
   function automatic logic [7:0] xdeg(input logic signed [11:0] t);
      logic signed [12:0] s;
      s = t;
      s = (s + 13'sh0002) >>> 2;
      return s > 13'sh007F ? 8'h7F : s < 13'sh1F80 ? 8'h80 : s[7:0];
   endfunction
   // Note the reported value before the byte goes out
   task automatic put(input logic [7:0] w, input logic m, input logic r,
                      input logic [7:0] e);
      exp_q.push_back(e);
      tsr_host_model_inst.xfer(w, m, r);
   endtask
   task automatic wr(input logic [7:0] c, input logic [7:0] d);
      tsr_host_model_inst.start();
      put(8'h90, 1'b1, 1'b0, 8'h00);
      put(c, 1'b1, 1'b0, 8'h00);
      put(d, 1'b1, 1'b0, 8'h00);
      tsr_host_model_inst.stop();
   endtask
   task automatic rcv(input logic [7:0] e);
      tsr_host_model_inst.start();
      put(8'h91, 1'b1, 1'b0, 8'h00);
      put(8'hFF, 1'b1, 1'b1, e);
      tsr_host_model_inst.stop();
   endtask
   task automatic rd(input logic [7:0] c, input logic [7:0] e);
      tsr_host_model_inst.start();
      put(8'h90, 1'b1, 1'b0, 8'h00);
      put(c, 1'b1, 1'b0, 8'h00);
      rcv(e);
   endtask
   task automatic wait_rdy();
      int n = 0;
      while (ready !== 1'b1 && n < 2000)
      begin
         @(negedge clk);
         n++;
      end
      chk("ready", 8'h01, {7'h00, ready});
   endtask
   task automatic tally_and_finish();
      $display("checked %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Every reported byte against the oldest note
   always @(posedge clk)
      if (got === 1'b1 && exp_q.size() == 0)
      begin
         err_count++;
         $display("unexpected bus byte exp none got %h", rx);
      end
      else if (got === 1'b1)
         chk("bus byte", exp_q.pop_front(), rx);
   // Run needs about 20k cycles; a hang ends here
   initial
   begin
      repeat (60000) @(posedge clk);
      err_count++;
      tally_and_finish();
   end
   initial
   begin
      tv = '{12'sh1FA, 12'sh002, 12'shFFE, 12'shFFD, 12'sh208, 12'sh064,
             12'shF37, 12'sh800};
      void'($urandom(30));
      repeat (16) @(negedge clk);
      rst = 1'b0;
      chk("degrees", 8'h00, deg);
      chk("sda drive", 8'h00, {7'h00, sda_out});
      rd(8'h00, 8'h00);
      rd(8'h01, 8'h00);
      wait_rdy();
      // Boundary table first, then random samples at random bus speed
      for (int i = 0; i < 12; i++)
      begin
         q = i < 8 ? tv[i] : 12'($urandom);
         if (i >= 8)
            tsr_host_model_inst.half = 3 + $urandom_range(3);
         repeat (CONV + 4) @(negedge clk);
         rd(8'h00, xdeg(q));
      end
      rcv(xdeg(q));
      wr(8'h01, 8'h3F);
      rd(8'h01, 8'h40);
      // Master ack re-sends the same register
      tsr_host_model_inst.start();
      put(8'h91, 1'b1, 1'b0, 8'h00);
      put(8'hFF, 1'b0, 1'b1, 8'h40);
      put(8'hFF, 1'b1, 1'b1, 8'h40);
      tsr_host_model_inst.stop();
      wr(8'h00, 8'h55);
      rcv(xdeg(q));
      wr(8'h01, 8'hFF);
      chk("standby", 8'h01, {7'h00, standby});
      rd(8'h01, 8'h80);
      v = xdeg(q);
      q = 12'sh050;
      repeat (CONV + 4) @(negedge clk);
      rd(8'h00, v);
      wr(8'h01, 8'h00);
      rd(8'h01, 8'h00);
      wait_rdy();
      rd(8'h00, 8'h14);
      // Foreign address is left unanswered
      tsr_host_model_inst.start();
      put(8'h92, 1'b1, 1'b0, 8'h01);
      tsr_host_model_inst.stop();
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      chk("reset degrees", 8'h00, deg);
      tally_and_finish();
   end
endmodule
`default_nettype wire
